// file: can_ts_params.svh
// constants for the set/clear register file and the time stamp unit
// assumes a 32-bit word bus where each register sits on an aligned word
`ifndef CAN_TS_PARAMS_SVH
`define CAN_TS_PARAMS_SVH

// register byte offsets
`define OFS_GLOBAL_STATUS      12'h000
`define OFS_GLOBAL_INT_ENABLE  12'h004
`define OFS_CH1_CONTROL        12'h008
`define OFS_CH1_DEFINITION     12'h00c
`define OFS_CH1_INT_ENABLE     12'h010
`define OFS_CH2_CONTROL        12'h014
`define OFS_CH2_DEFINITION     12'h018
`define OFS_CH2_INT_ENABLE     12'h01c
`define OFS_STAMP_COUNTER      12'h020
`define OFS_TX_INSERT_ENABLE   12'h024
`define OFS_CAPTURE_VALID      12'h028
`define OFS_STAMP_BASE         12'h080
`define OFS_STAMP_LAST         12'h0fc
`define OFS_SHARED_LAST        12'h01c

// shared register layout
`define SHARED_REG_COUNT       8
`define SHARED_WIDTH           8
`define SET_FIELD_LSB          8
`define CH_CONTROL_IDX0        3'd2
`define CH_CONTROL_IDX1        3'd5
`define GLOBAL_STATUS_IDX      3'd0
`define RX_CAPTURE_POINT_BIT   3
`define STAMP_MODE_BIT         7
`define SHARED_RESET           8'h00

// time stamp and frame figures
`define STAMP_WIDTH            16
`define STAMP_BUF_COUNT        32
`define CHANNEL_COUNT          2
`define DLC_MAX_BYTES          4'd8
`define STAMP_BYTES            4'd2
`define COUNTER_RESET          16'h0000
`define INSERT_ENABLE_RESET    32'h0000_0000

`endif

// file: can_ts_pkg.sv
// types shared by the set/clear register and the time stamp top level
// assumes can_ts_params.svh for all figures
package can_ts_pkg;

    // phase of the single outstanding bus transfer
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ
    } bus_phase_type;

    // state of one set/clear register
    typedef struct packed {
        logic [7:0] value;
    } setclear_state_type;

    // all flip-flops of the top level except the stamp memory and validReg_q
    typedef struct packed {
        bus_phase_type   phase;
        logic [11:0]     addr;
        logic            readyOut;
        logic [31:0]     rdata;
        logic [15:0]     counter;
        logic [31:0]     insertEn;
        logic [1:0][15:0] rxSofStamp;
        logic [1:0][15:0] txStamp;
        logic [1:0]      txInsert;
        logic [1:0][7:0] txByteOut;
        logic [1:0]      txByteValid;
    } top_state_type;

endpackage

// file: setclear_reg.sv
// one 8-bit register written through the set/clear format
// assumes the caller decodes the address and pulses swWrite for one cycle
`timescale 1ns/100ps
`include "can_ts_params.svh"

module setclear_reg
    import can_ts_pkg::*;
(
    input  logic       clk,
    input  logic       rst,
    input  logic       swWrite,
    input  logic [7:0] swSet,
    input  logic [7:0] swClr,
    input  logic [7:0] hwSet,
    input  logic [7:0] hwClr,
    output logic [7:0] value
);
    setclear_state_type state_q;
    setclear_state_type state_d;
    logic [7:0]         swChange;

    ////////////////////////////////////////////////////////////////////////
    // per bit: only one of set/clear changes the bit; hardware set wins,
    // then a software change, then a hardware clear, so no hardware set is lost
    always_comb begin
        state_d  = state_q;
        swChange = swWrite ? (swSet ^ swClr) : 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (hwSet[i]) begin
                state_d.value[i] = 1'b1;
            end else if (swChange[i]) begin
                state_d.value[i] = swSet[i];
            end else if (hwClr[i]) begin
                state_d.value[i] = 1'b0;
            end
        end
    end

    // register the state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '{value: `SHARED_RESET};
        end else begin
            state_q <= state_d;
        end
    end

    assign value = state_q.value;

endmodule

// file: can_setclear_and_timestamp.sv
// set/clear register file shared by cpu and protocol side, plus the
// free-running time stamp counter with per-buffer capture and tx insertion
// assumes an ahb-lite master and a protocol engine that reports frame
// events as one-cycle pulses synchronous to clk
`timescale 1ns/100ps
`include "can_ts_params.svh"

// Functional notes
// - cpu and protocol both change shared bits
// - shared registers read back eight bits, 15:8 zero
// - write bits 15:8 set, 7:0 clear
// - one request changes bit, zero or two keep
// - sixteen-bit free-running stamp counter
// - control bit 3 picks sof or eof capture
// - each of 32 buffers keeps its stamp
// - per-buffer flag inserts sof stamp on transmit
// - low byte second-last, high last, dlc>8=8
// - reduced variant: eof capture only, valid flag
module can_setclear_and_timestamp
    import can_ts_pkg::*;
#(
    parameter bit SOF_STAMP_SUPPORTED = 1'b1
)
(
    input  logic        clk,
    input  logic        rst,
    // ahb-lite slave
    input  logic        hsel,
    input  logic [31:0] haddr,
    input  logic [1:0]  htrans,
    input  logic        hwrite,
    input  logic [2:0]  hsize,
    input  logic [31:0] hwdata,
    input  logic        hready,
    output logic        hreadyout,
    output logic        hresp,
    output logic [31:0] hrdata,
    // protocol side access to the shared bits, 8 per register
    input  logic [63:0] protoSet,
    input  logic [63:0] protoClr,
    output logic [63:0] sharedBits,
    // per-channel frame events
    input  logic [1:0]  rxSof,
    input  logic [1:0]  rxEof,
    input  logic [1:0]  rxStore,
    input  logic [9:0]  rxStoreBuf,
    input  logic [1:0]  txSof,
    input  logic [9:0]  txBuf,
    // per-channel transmit byte path, then the stamp counter and capture-valid flags
    input  logic [1:0]  txByteReq,
    input  logic [5:0]  txByteIdx,
    input  logic [7:0]  txDlc,
    input  logic [15:0] txByteIn,
    output logic [15:0] txByteOut,
    output logic [1:0]  txByteValid,
    output logic [15:0] stampCounter,
    output logic [1:0]  captureValid
);
    import can_ts_pkg::*;

    top_state_type state_q;
    top_state_type state_d;
    logic [15:0]   stampMem [0:`STAMP_BUF_COUNT-1];
    logic [7:0]    swWrite;
    logic [7:0]    regValue [0:`SHARED_REG_COUNT-1];
    logic [1:0]    capturePoint;
    logic          stampMode;
    logic [1:0]    validFlag;
    logic [1:0]    rxCapture;
    logic [1:0]    rxUseSof;
    logic          addrPhase;
    logic [1:0]    validReg_q;
    logic [1:0][8:0] insByte;

    ////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // true when the byte address names one of the shared registers
    function automatic logic isShared(input logic [11:0] a);
        isShared = (a <= `OFS_SHARED_LAST) && (a[1:0] == 2'b00);
    endfunction

    // true when the byte address lies in the stamp window
    function automatic logic isStamp(input logic [11:0] a);
        isStamp = (a >= `OFS_STAMP_BASE) && (a <= `OFS_STAMP_LAST);
    endfunction

    // stamp byte carried at position idx of a frame with length code dlc
    function automatic logic [8:0] insertByte(
        input logic [2:0]  idx,
        input logic [3:0]  dlc,
        input logic [15:0] stamp
    );
        logic [3:0] len;
        len = (dlc > `DLC_MAX_BYTES) ? `DLC_MAX_BYTES : dlc;
        insertByte = 9'h000;
        if (len >= `STAMP_BYTES) begin
            if ({1'b0, idx} == len - 4'd2) begin
                insertByte = {1'b1, stamp[7:0]};
            end else if ({1'b0, idx} == len - 4'd1) begin
                insertByte = {1'b1, stamp[15:8]};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // shared set/clear registers

    // one instance per shared register; protocol side gets its own byte
    generate
        for (genvar r = 0; r < `SHARED_REG_COUNT; r++) begin : g_shared
            setclear_reg u_reg (
                .clk     (clk),
                .rst     (rst),
                .swWrite (swWrite[r]),
                .swSet   (hwdata[`SET_FIELD_LSB +: 8]),
                .swClr   (hwdata[7:0]),
                .hwSet   (protoSet[r*8 +: 8]),
                .hwClr   (protoClr[r*8 +: 8]),
                .value   (regValue[r])
            );
            assign sharedBits[r*8 +: 8] = regValue[r];
        end
    endgenerate

    // capture mode bits taken straight from the shared registers
    assign stampMode = regValue[`GLOBAL_STATUS_IDX][`STAMP_MODE_BIT];
    assign capturePoint[0] =
        regValue[`CH_CONTROL_IDX0][`RX_CAPTURE_POINT_BIT];
    assign capturePoint[1] =
        regValue[`CH_CONTROL_IDX1][`RX_CAPTURE_POINT_BIT];
    assign validFlag = {2{stampMode}} & capturePoint;

    ////////////////////////////////////////////////////////////////////////
    // reception capture decision per channel

    // sof mode uses the stamp latched at start of frame; eof mode stamps
    // at store time. a reduced part only stamps in the validated eof mode
    always_comb begin
        for (int c = 0; c < `CHANNEL_COUNT; c++) begin
            if (SOF_STAMP_SUPPORTED) begin
                rxUseSof[c]  = !capturePoint[c];
                rxCapture[c] = rxStore[c];
            end else begin
                rxUseSof[c]  = 1'b0;
                rxCapture[c] = rxStore[c] && validFlag[c];
            end
        end
    end

    // bus address phase of a transfer the slave must take
    assign addrPhase = hsel && hready && htrans[1];

    ////////////////////////////////////////////////////////////////////////
    // next-state logic of everything but the stamp memory and validReg_q

    always_comb begin
        state_d = state_q;
        swWrite = 8'h00;
        state_d.txByteValid = 2'b00;

        // free-running, wraps at 16 bits
        state_d.counter = state_q.counter + 16'h0001;

        // data phase of a write: zero wait states
        if (state_q.phase == BUS_WRITE) begin
            if (isShared(state_q.addr)) begin
                swWrite[state_q.addr[4:2]] = 1'b1;
            end else if (state_q.addr == `OFS_TX_INSERT_ENABLE) begin
                state_d.insertEn = hwdata;
            end
            state_d.phase = BUS_IDLE;
        end

        // data phase of a read: one wait state so a write just before it
        // is already visible in the value returned
        if (state_q.phase == BUS_READ) begin
            state_d.rdata = 32'h0000_0000;
            if (isShared(state_q.addr)) begin
                state_d.rdata[15:0] =
                    {8'h00, regValue[state_q.addr[4:2]]};
            end else if (isStamp(state_q.addr)) begin
                state_d.rdata[15:0] = stampMem[state_q.addr[6:2]];
            end else if (state_q.addr == `OFS_STAMP_COUNTER) begin
                state_d.rdata[15:0] = state_q.counter;
            end else if (state_q.addr == `OFS_TX_INSERT_ENABLE) begin
                state_d.rdata = state_q.insertEn;
            end else if (state_q.addr == `OFS_CAPTURE_VALID) begin
                state_d.rdata[1:0] = validFlag;
            end
            state_d.readyOut = 1'b1;
            state_d.phase    = BUS_IDLE;
        end

        // address phase; unmapped addresses read zero, writes are dropped
        if (addrPhase) begin
            state_d.addr = haddr[11:0];
            if (hwrite) begin
                state_d.phase = BUS_WRITE;
            end else begin
                state_d.phase    = BUS_READ;
                state_d.readyOut = 1'b0;
            end
        end

        // per-channel frame events
        for (int c = 0; c < `CHANNEL_COUNT; c++) begin
            if (rxSof[c] && SOF_STAMP_SUPPORTED) begin
                state_d.rxSofStamp[c] = state_q.counter;
            end
            if (txSof[c] && SOF_STAMP_SUPPORTED) begin
                state_d.txStamp[c]  = state_q.counter;
                state_d.txInsert[c] =
                    state_q.insertEn[txBuf[c*5 +: 5]];
            end
            // outgoing byte, replaced by the stamp in the last two slots
            insByte[c] = insertByte(txByteIdx[c*3 +: 3], txDlc[c*4 +: 4],
                                    state_q.txStamp[c]);
            if (txByteReq[c]) begin
                state_d.txByteValid[c] = 1'b1;
                state_d.txByteOut[c]   = txByteIn[c*8 +: 8];
                if (state_q.txInsert[c] && insByte[c][8]) begin
                    state_d.txByteOut[c] = insByte[c][7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q             <= '0;
            state_q.phase       <= BUS_IDLE;
            state_q.readyOut    <= 1'b1;
            state_q.counter     <= `COUNTER_RESET;
            state_q.insertEn    <= `INSERT_ENABLE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-buffer stamp memory

    // channel 2 writes after channel 1 and rx after tx, so on a clash of
    // buffer numbers in one cycle the later writer wins; software never
    // maps one buffer to both channels, so this only affects misuse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int b = 0; b < `STAMP_BUF_COUNT; b++) begin
                stampMem[b] <= 16'h0000;
            end
        end else begin
            for (int c = 0; c < `CHANNEL_COUNT; c++) begin
                if (txSof[c] && SOF_STAMP_SUPPORTED) begin
                    stampMem[txBuf[c*5 +: 5]] <= state_q.counter;
                end
                if (rxCapture[c]) begin
                    stampMem[rxStoreBuf[c*5 +: 5]] <= rxUseSof[c] ?
                        state_q.rxSofStamp[c] : state_q.counter;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops, hresp tied to zero

    assign hreadyout    = state_q.readyOut;
    assign hresp        = 1'b0;                  // always okay
    assign hrdata       = state_q.rdata;
    assign stampCounter = state_q.counter;
    assign txByteValid  = state_q.txByteValid;
    assign captureValid = validReg_q;

    // capture-valid flags registered so the port comes from a flip-flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            validReg_q <= 2'b00;
        end else begin
            validReg_q <= validFlag;
        end
    end

    // byte lanes of the two channels
    generate
        for (genvar c = 0; c < `CHANNEL_COUNT; c++) begin : g_txout
            assign txByteOut[c*8 +: 8] = state_q.txByteOut[c];
        end
    endgenerate

endmodule

// file: can_setclear_and_timestamp_properties.sv
// port-level checks for the set/clear registers and time stamp unit
// assumes it is bound to the top level and sees only its ports
`timescale 1ns/100ps

module can_ts_checker (
    input logic        clk,
    input logic        rst,
    input logic        hsel,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic        hready,
    input logic        hreadyout,
    input logic        hresp,
    input logic [63:0] protoSet,
    input logic [63:0] protoClr,
    input logic [63:0] sharedBits,
    input logic [1:0]  txByteReq,
    input logic [1:0]  txByteValid,
    input logic [15:0] stampCounter,
    input logic [1:0]  captureValid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////
    // two-cycle window after a write, so either update edge is excused
    logic [1:0] wrPend_q;
    logic       wrTake;
    logic       rdTake;
    assign wrTake = hsel & hready & htrans[1] & hwrite;
    assign rdTake = hsel & hready & htrans[1] & ~hwrite;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPend_q <= 2'b00;
        end else begin
            wrPend_q <= {wrPend_q[0], wrTake};
        end
    end

    ////////////////////////////////////////////////////////////////////
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    chk_read_wait: assert property (
        rdTake |=> !hreadyout ##1 hreadyout)
        else $error("read wait cycle wrong");
    chk_write_nowait: assert property (wrTake |=> hreadyout)
        else $error("write inserted a wait");
    // the first edge after release still sees the reset value
    chk_counter_step: assert property (
        !$past(rst) |-> stampCounter == $past(stampCounter) + 16'h0001)
        else $error("stamp counter did not step by one");
    chk_tx_answer: assert property (txByteReq[0] |=> txByteValid[0])
        else $error("tx byte not answered");
    chk_tx_quiet: assert property (!txByteReq[0] |=> !txByteValid[0])
        else $error("tx byte valid without request");
    chk_proto_set: assert property (protoSet[0] |=> sharedBits[0])
        else $error("protocol set lost");
    chk_proto_clr: assert property (
        protoClr[8] && !protoSet[8] && wrPend_q == 2'b00
        |=> !sharedBits[8])
        else $error("protocol clear lost");
    chk_bits_hold: assert property (
        protoSet[7:0] == 8'h00 && protoClr[7:0] == 8'h00
        && wrPend_q == 2'b00 |=> $stable(sharedBits[7:0]))
        else $error("shared bits changed with no request");
    chk_capture_flag: assert property (
        captureValid[0] == $past(sharedBits[7] & sharedBits[19]))
        else $error("capture valid flag wrong");

    cover property (rdTake);
    cover property (txByteValid[0]);
    cover property (captureValid[0]);
endmodule

bind can_setclear_and_timestamp can_ts_checker i_chk (
    .clk, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .protoSet, .protoClr, .sharedBits, .txByteReq, .txByteValid,
    .stampCounter, .captureValid);

// file: can_bus_partner.sv
// protocol engine stand-in: frame events and tx byte requests on channel 0
// assumes callers enter each task just after a rising clock edge
`timescale 1ns/100ps

module can_bus_partner (
    input  logic        clk,
    input  logic [15:0] stampCounter,
    input  logic [15:0] txByteOut,
    input  logic [1:0]  txByteValid,
    output logic [1:0]  rxSof,
    output logic [1:0]  rxEof,
    output logic [1:0]  rxStore,
    output logic [9:0]  rxStoreBuf,
    output logic [1:0]  txSof,
    output logic [9:0]  txBuf,
    output logic [1:0]  txByteReq,
    output logic [5:0]  txByteIdx,
    output logic [7:0]  txDlc,
    output logic [15:0] txByteIn
);
    // quiet bus at time zero; channel 1 stays idle
    initial begin
        {rxSof, rxEof, rxStore, txSof, txByteReq} = '0;
        {rxStoreBuf, txBuf, txByteIdx, txDlc} = '0;
        txByteIn = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////
    // receive frame: counter seen at sof and at the store edge
    // buffers below 31 only, as the two-channel sof case demands
    task automatic rxFrame(input logic [4:0] b, output logic [15:0] sofT,
                           output logic [15:0] eofT);
        rxSof <= 2'b01;
        @(posedge clk);
        sofT = stampCounter;
        rxSof <= 2'b00;
        repeat (5) @(posedge clk);
        rxEof <= 2'b01;
        rxStore <= 2'b01;
        rxStoreBuf <= {5'd0, b};
        @(posedge clk);
        eofT = stampCounter;
        rxEof <= 2'b00;
        rxStore <= 2'b00;
    endtask

    // one transmit at a time; stamp frames get more than two bytes
    task automatic txFrame(input logic [4:0] b,
                           output logic [15:0] t);
        txSof <= 2'b01;
        txBuf <= {5'd0, b};
        @(posedge clk);
        t = stampCounter;
        txSof <= 2'b00;
    endtask

    // data line is scrambled once the byte has been taken
    task automatic txByte(input logic [2:0] i, input logic [3:0] dlc,
                          input logic [7:0] din, output logic [7:0] dout,
                          output logic v);
        txByteReq <= 2'b01;
        txByteIdx <= {3'd0, i};
        txDlc <= {4'd0, dlc};
        txByteIn <= {8'h00, din};
        @(posedge clk);
        txByteReq <= 2'b00;
        txByteIn <= ~txByteIn;
        @(posedge clk);
        dout = txByteOut[7:0];
        v = txByteValid[0];
    endtask
endmodule

// file: can_setclear_and_timestamp_bench.sv
// self-checking bench: ahb-lite register access plus frame events
// assumes the partner model drives every frame event input; protoSet and protoClr come from the bench
`timescale 1ns/100ps

module can_setclear_and_timestamp_bench;
    logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, cyc;
    logic [1:0]  htrans, rxSof, rxEof, rxStore, txSof, txByteReq;
    logic [1:0]  txByteValid, captureValid;
    logic [2:0]  hsize;
    logic [63:0] protoSet, protoClr, sharedBits;
    logic [9:0]  rxStoreBuf, txBuf;
    logic [5:0]  txByteIdx;
    logic [7:0]  txDlc;
    logic [15:0] txByteIn, txByteOut, stampCounter;
    int          mismatches, nCompared;

    assign hready = hreadyout;
    can_setclear_and_timestamp i_dut (.clk, .rst, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .protoSet, .protoClr, .sharedBits, .rxSof, .rxEof, .rxStore,
        .rxStoreBuf, .txSof, .txBuf, .txByteReq, .txByteIdx, .txDlc,
        .txByteIn, .txByteOut, .txByteValid, .stampCounter, .captureValid);
    can_bus_partner i_partner (.clk, .stampCounter, .txByteOut,
        .txByteValid, .rxSof, .rxEof, .rxStore, .rxStoreBuf, .txSof,
        .txBuf, .txByteReq, .txByteIdx, .txDlc, .txByteIn);

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // edges since reset release, to predict the counter
    always @(posedge clk or posedge rst) begin
        if (rst) cyc <= 32'h0;
        else cyc <= cyc + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        nCompared++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // single word transfer; waits on hready, never a fixed count
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // writes to shared registers always carry set/clear halves
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input string n, input logic [11:0] a,
                      input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(n, e, r);
    endtask
    function automatic logic [7:0] sc(logic [7:0] v, s, c);
        return (v & ~(s ^ c)) | (s & ~c);
    endfunction
    task automatic test_done();
        $display("mismatches %0d compared %0d", mismatches, nCompared);
        if (mismatches == 0 && nCompared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done();
    end

    initial begin
        logic [15:0] s, e, s2, e2, t;
        logic [7:0]  ex, o, v8;
        logic [3:0]  dlc, len;
        logic        v, ins;
        rst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        protoSet = 64'h0;
        protoClr = 64'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int r = 0; r < 8; r++) rd("reset", 12'(r * 4), 32'h0);
        wr(12'h040, 32'h0000_ff00);
        rd("unmapped", 12'h040, 32'h0);
        // two set/clear writes per register, upper half is junk
        for (int r = 0; r < 8; r++) begin
            v8 = sc(8'h00, 8'h3c | 8'(r), 8'h00);
            wr(12'(r * 4), {16'hdead, 8'h3c | 8'(r), 8'h00});
            v8 = sc(v8, 8'h55, 8'h33);
            wr(12'(r * 4), 32'hbeef_5533);
            rd("shared", 12'(r * 4), {24'h0, v8});
            chk("bits", {24'h0, v8}, {24'h0, sharedBits[r*8+:8]});
        end
        // protocol set beats a software clear
        protoSet <= 64'h1;
        wr(12'h000, 32'h0000_00ff);
        @(posedge clk);
        protoSet <= 64'h0;
        rd("set wins", 12'h000, 32'h1);
        // software set beats protocol clear; untouched bit keeps hw set
        protoClr <= 64'h100;
        protoSet <= 64'h200;
        wr(12'h004, 32'h0000_01fc);
        protoClr <= 64'h0;
        protoSet <= 64'h0;
        rd("sw wins", 12'h004, 32'h3);
        @(negedge clk);
        chk("counter", {16'h0, cyc[15:0]}, {16'h0, stampCounter});
        @(posedge clk);
        // read data is latched two edges after the request is made
        rd("counter reg", 12'h020, {16'h0, cyc[15:0] + 16'h0002});
        // capture at sof, then at store; buffers keep their own stamp
        wr(12'h008, 32'h0000_00ff);
        i_partner.rxFrame(5'd3, s, e);
        rd("sof stamp", 12'h08c, {16'h0, s});
        wr(12'h008, 32'h0000_0800);
        i_partner.rxFrame(5'd4, s2, e2);
        rd("eof stamp", 12'h090, {16'h0, e2});
        rd("kept stamp", 12'h08c, {16'h0, s});
        // channel 2 control still holds bit 3 from the loop above
        wr(12'h000, 32'h0000_8000);
        repeat (3) @(posedge clk);
        chk("valid on", 32'h3, {30'h0, captureValid});
        rd("valid reg", 12'h028, 32'h3);
        wr(12'h008, 32'h0000_0008);
        repeat (3) @(posedge clk);
        chk("valid off", 32'h2, {30'h0, captureValid});
        // stamp insertion on buffer 5 only, lengths 3, 8, 12, then 4
        wr(12'h024, 32'h0000_0020);
        rd("insert en", 12'h024, 32'h0000_0020);
        for (int k = 0; k < 4; k++) begin
            dlc = (k == 0) ? 4'd3 : (k == 1) ? 4'd8 : (k == 2) ? 4'd12 : 4'd4;
            ins = (k != 3);
            i_partner.txFrame(ins ? 5'd5 : 5'd6, t);
            len = (dlc > 4'd8) ? 4'd8 : dlc;
            for (int i = 0; i < len; i++) begin
                i_partner.txByte(3'(i), dlc, 8'ha0 + 8'(i), o, v);
                ex = 8'ha0 + 8'(i);
                if (ins && i == len - 2) ex = t[7:0];
                if (ins && i == len - 1) ex = t[15:8];
                chk("tx valid", 32'h1, {31'h0, v});
                chk("tx byte", {24'h0, ex}, {24'h0, o});
            end
        end
        // the last transmit used buffer 6, which keeps its sof stamp
        rd("tx stamp", 12'h098, {16'h0, t});
        test_done();
    end
endmodule
